// ---- core/cce_exec_unit.sv ----
// Purpose: Executes watchdog clear, call, complement, clear-file, decrement
//          and clear-accumulator on the core instruction clock.
// Assumes: The decoder presents one instruction with i_valid; the file read
//          data for i_instr.faddr arrives on i_file_rdata in the same cycle.
// Notes:   All side effects are registered; they appear one cycle after issue.
//          An instruction offered in the second cycle of a call is dropped
//          without any side effect, and the decoder must offer it again.
//          The file read data is used as presented; a write-back still in
//          flight to the same address is not forwarded here.
//          The watchdog counter and its prescaler are only ever cleared by
//          this unit; their counting belongs to the watchdog itself.
//          Every payload field reads zero while its strobe is low, so the
//          parties downstream never see a stale address or result.
module cce_exec_unit (
    // Clock and reset
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rstn,
    // Decoded instruction
    input  wire logic                       i_valid,
    input  wire cce_pkg::cce_instr_type     i_instr,
    // Core state
    input  wire logic [cce_pkg::DATA_W-1:0]  i_file_rdata,
    input  wire logic [cce_pkg::LATCH_W-1:0] i_pc_upper_latch,
    // Program counter
    output logic [cce_pkg::PC_W-1:0]        o_pc,
    output logic                            o_busy,
    // Results
    output cce_pkg::cce_fwrite_type         o_fwrite,
    output logic                            o_acc_we,
    output logic [cce_pkg::DATA_W-1:0]      o_acc_wdata,
    output cce_pkg::cce_status_type         o_status,
    output cce_pkg::cce_push_type           o_stack_top,
    // Watchdog
    output logic                            o_watchdog_clear,
    output logic [cce_pkg::WDT_W-1:0]       o_watchdog_counter,
    output logic [cce_pkg::PRE_W-1:0]       o_watchdog_prescaler
);
    import cce_pkg::*;

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == ZERO_BYTE);
    endfunction

    logic [PC_W-1:0]        pc_ff;
    logic                   busy_ff;
    cce_fwrite_type         fwrite_ff;
    logic                   acc_we_ff;
    logic [DATA_W-1:0]      acc_wdata_ff;
    cce_status_type         status_ff;
    cce_push_type           push_ff;
    logic                   wdclr_ff;
    logic [WDT_W-1:0]       wdt_ff;
    logic [PRE_W-1:0]       pre_ff;

    wire logic go = i_valid && !busy_ff;
    wire cce_op_type op = go ? i_instr.op : CCE_OP_NONE;

    wire logic is_wdc  = (op == CCE_OP_WATCHDOG_CLEAR);
    wire logic is_call = (op == CCE_OP_CALL);
    wire logic is_com  = (op == CCE_OP_COMPLEMENT);
    wire logic is_clear_file_op = (op == CCE_OP_CLEAR_FILE);
    wire logic is_dec  = (op == CCE_OP_DECREMENT);
    wire logic is_clear_accumulator_op = (op == CCE_OP_CLEAR_ACC);

    // Arithmetic result for the read-modify-write operations.
    wire logic [DATA_W-1:0] alu_res = is_com ? ~i_file_rdata
                                    : is_dec ? i_file_rdata - ONE_BYTE
                                    : ZERO_BYTE;
    wire logic rmw      = is_com || is_dec;
    wire logic to_file  = (rmw && i_instr.dest == DEST_FILE) || is_clear_file_op;
    wire logic to_acc   = (rmw && i_instr.dest == DEST_ACC) || is_clear_accumulator_op;
    wire logic z_update = rmw || is_clear_file_op || is_clear_accumulator_op;
    wire logic z_value  = is_zero(alu_res);

    // Call target: latch bits four:three above the eleven-bit operand.
    wire logic [PC_W-1:0] call_pc = {i_pc_upper_latch[LATCH_HI:LATCH_LO],
                                     i_instr.target};
    wire logic [PC_W-1:0] ret_pc  = pc_ff + PC_STEP;
    wire logic [PC_W-1:0] nxt_pc  = is_call ? call_pc
                                  : (go ? ret_pc : pc_ff);

    // Payloads are forced to zero while their strobe is low, so an idle output
    // never carries a stale address, result or return address.
    wire logic [FADDR_W-1:0] file_addr = to_file ? i_instr.faddr : '0;
    wire logic [DATA_W-1:0]  file_data = to_file ? alu_res : ZERO_BYTE;
    wire logic [DATA_W-1:0]  acc_data  = to_acc ? alu_res : ZERO_BYTE;
    wire logic [PC_W-1:0]    push_addr = is_call ? ret_pc : '0;

    // A call or a watchdog clear must show no zero-flag activity, so the
    // zero value is only driven together with its write enable.
    wire logic               z_write   = z_update && z_value;

    // Next values of the result registers.
    wire logic               nxt_busy      = is_call;
    wire cce_fwrite_type     nxt_fwrite    = '{we:   to_file,
                                               addr: file_addr,
                                               data: file_data};
    wire logic               nxt_acc_we    = to_acc;
    wire logic [DATA_W-1:0]  nxt_acc_wdata = acc_data;
    wire cce_status_type     nxt_status    = '{z_we:  z_update,
                                               z_val: z_write,
                                               to_we: is_wdc,
                                               pd_we: is_wdc};
    wire cce_push_type       nxt_push      = '{push: is_call,
                                               addr: push_addr};
    wire logic               nxt_wdclr     = is_wdc;
    wire logic [WDT_W-1:0]   nxt_wdt       = is_wdc ? WDT_CLEAR : wdt_ff;
    wire logic [PRE_W-1:0]   nxt_pre       = is_wdc ? PRE_CLEAR : pre_ff;

    // The program counter holds while a call occupies its second cycle.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pc_ff <= PC_RESET;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    // Marks the second cycle of a call, in which a new instruction is refused.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= nxt_busy;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fwrite_ff <= '0;
        end else begin
            fwrite_ff <= nxt_fwrite;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            acc_we_ff <= 1'b0;
        end else begin
            acc_we_ff <= nxt_acc_we;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            acc_wdata_ff <= ZERO_BYTE;
        end else begin
            acc_wdata_ff <= nxt_acc_wdata;
        end
    end

    // Call touches no flag; watchdog clear only sets its two bits.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            status_ff <= '0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // The return address is taken before the program counter moves.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            push_ff <= '0;
        end else begin
            push_ff <= nxt_push;
        end
    end

    // One-cycle strobe telling the watchdog that its count was just cleared.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wdclr_ff <= 1'b0;
        end else begin
            wdclr_ff <= nxt_wdclr;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wdt_ff <= WDT_CLEAR;
        end else begin
            wdt_ff <= nxt_wdt;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_ff <= PRE_CLEAR;
        end else begin
            pre_ff <= nxt_pre;
        end
    end

    // Every output comes straight from its register.
    assign o_pc                 = pc_ff;
    assign o_busy               = busy_ff;
    assign o_fwrite             = fwrite_ff;
    assign o_acc_we             = acc_we_ff;
    assign o_acc_wdata          = acc_wdata_ff;
    assign o_status             = status_ff;
    assign o_stack_top          = push_ff;
    assign o_watchdog_clear     = wdclr_ff;
    assign o_watchdog_counter   = wdt_ff;
    assign o_watchdog_prescaler = pre_ff;
endmodule

// ---- shared/cce_pkg.sv ----
// Purpose: Shared constants and types for the clear/call/decrement execution unit.
// Assumes: 8-bit data, 7-bit file address, 13-bit program counter.
// Notes:   Operation codes are local to this unit, not instruction encodings.
package cce_pkg;
    localparam int DATA_W     = 8;
    localparam int FADDR_W    = 7;
    localparam int PC_W       = 13;
    localparam int TARGET_W   = 11;
    localparam int LATCH_W    = 8;
    localparam int LATCH_LO   = 3;
    localparam int LATCH_HI   = 4;
    localparam int WDT_W      = 8;
    localparam int PRE_W      = 8;
    localparam int CALL_CYC   = 2;

    localparam logic [DATA_W-1:0]   ZERO_BYTE  = 8'h00;
    localparam logic [DATA_W-1:0]   ONE_BYTE   = 8'h01;
    localparam logic [PC_W-1:0]     PC_STEP    = 13'h0001;
    localparam logic [PC_W-1:0]     PC_RESET   = 13'h0000;
    localparam logic [WDT_W-1:0]    WDT_CLEAR  = 8'h00;
    localparam logic [PRE_W-1:0]    PRE_CLEAR  = 8'h00;
    localparam logic                DEST_ACC   = 1'b0;
    localparam logic                DEST_FILE  = 1'b1;

    typedef enum logic [2:0] {
        CCE_OP_NONE,
        CCE_OP_WATCHDOG_CLEAR,
        CCE_OP_CALL,
        CCE_OP_COMPLEMENT,
        CCE_OP_CLEAR_FILE,
        CCE_OP_DECREMENT,
        CCE_OP_CLEAR_ACC
    } cce_op_type;

    // One decoded instruction as presented by the decoder.
    typedef struct packed {
        cce_op_type             op;
        logic [FADDR_W-1:0]     faddr;
        logic                   dest;
        logic [TARGET_W-1:0]    target;
    } cce_instr_type;

    // One file register write-back.
    typedef struct packed {
        logic                   we;
        logic [FADDR_W-1:0]     addr;
        logic [DATA_W-1:0]      data;
    } cce_fwrite_type;

    // Status flag update: write enables for Z, time-out and power-down, and a value for Z.
    typedef struct packed {
        logic                   z_we;
        logic                   z_val;
        logic                   to_we;
        logic                   pd_we;
    } cce_status_type;

    // Return stack push.
    typedef struct packed {
        logic                   push;
        logic [PC_W-1:0]        addr;
    } cce_push_type;
endpackage

// ---- verification/cce_exec_chk.sv ----
// Purpose: Port assertions for the execution unit.
// Assumes: Results show one cycle after an accepted instruction.
// Notes:   Bound from the bench top file.
module cce_exec_chk import cce_pkg::*; (
    // Clock and reset
    input wire logic                   i_ref_clk,
    input wire logic                   i_rstn,
    // Instruction side
    input wire logic                   i_valid,
    input wire cce_instr_type          i_instr,
    input wire logic [DATA_W-1:0]      i_file_rdata,
    input wire logic [LATCH_W-1:0]     i_pc_upper_latch,
    // Results
    input wire logic [PC_W-1:0]        o_pc,
    input wire logic                   o_busy,
    input wire cce_fwrite_type         o_fwrite,
    input wire logic                   o_acc_we,
    input wire logic [DATA_W-1:0]      o_acc_wdata,
    input wire cce_status_type         o_status,
    input wire cce_push_type           o_stack_top,
    // Watchdog
    input wire logic                   o_watchdog_clear,
    input wire logic [WDT_W-1:0]       o_watchdog_counter,
    input wire logic [PRE_W-1:0]       o_watchdog_prescaler
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    wire go = i_valid && !o_busy;
    wire c_w = go && i_instr.op == CCE_OP_WATCHDOG_CLEAR;
    wire c_c = go && i_instr.op == CCE_OP_CALL;
    wire c_m = go && i_instr.op == CCE_OP_COMPLEMENT;
    wire c_f = go && i_instr.op == CCE_OP_CLEAR_FILE;
    wire c_d = go && i_instr.op == CCE_OP_DECREMENT;
    wire c_a = go && i_instr.op == CCE_OP_CLEAR_ACC;
    wire [7:0] res = o_fwrite.we ? o_fwrite.data : o_acc_wdata;
    property p_wdt;
        c_w |=> o_watchdog_clear && !o_watchdog_counter && !o_watchdog_prescaler
            && {o_status.z_we, o_status.to_we, o_status.pd_we} == 3'b011;
    endproperty
    a_wdt: assert property (p_wdt) else $error("bad watchdog");
    property p_call;
        c_c |=> o_stack_top == {1'b1, $past(o_pc) + 13'h1}
            && o_pc == {$past(i_pc_upper_latch[4:3]), $past(i_instr.target)};
    endproperty
    a_call: assert property (p_call) else $error("bad call");
    property p_cyc;
        c_c |=> o_busy && !o_status ##1 !o_busy;
    endproperty
    a_cyc: assert property (p_cyc) else $error("bad call length");
    property p_com;
        c_m |=> res == ~$past(i_file_rdata) && o_status.z_we
            && o_status.z_val == ($past(i_file_rdata) == 8'hff);
    endproperty
    a_com: assert property (p_com) else $error("bad complement");
    property p_dst;
        c_m || c_d |=> o_fwrite.we == $past(i_instr.dest) && o_acc_we == !$past(i_instr.dest);
    endproperty
    a_dst: assert property (p_dst) else $error("bad destination");
    property p_dec;
        c_d |=> res == $past(i_file_rdata) - 8'h1 && o_status.z_val == ($past(i_file_rdata) == 8'h1);
    endproperty
    a_dec: assert property (p_dec) else $error("bad decrement");
    property p_clf;
        c_f |=> o_fwrite == {1'b1, $past(i_instr.faddr), 8'h0} && o_status.z_we && o_status.z_val;
    endproperty
    a_clf: assert property (p_clf) else $error("bad clear file");
    property p_cla;
        c_a |=> o_acc_we && !o_acc_wdata && o_status.z_we && o_status.z_val;
    endproperty
    a_cla: assert property (p_cla) else $error("bad clear acc");
    cover property (c_c ##1 i_valid);
    cover property (c_m ##1 c_d);
    cover property (c_w ##1 c_f);
endmodule

// ---- verification/cce_exec_unit_tb.sv ----
// Purpose: Self-checking bench for the execution unit.
// Assumes: Results show one cycle after an accepted instruction.
// Notes:   Expected results queue up in issue order.
module cce_exec_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cce_pkg::*;
    logic clk = 0, i_rstn = 0, i_valid = 0, o_busy, o_acc_we, o_wc;
    cce_instr_type i_instr = '0;
    logic [7:0] lat = 0, rdata, acc, wcnt, wpre;
    logic [12:0] o_pc, pc;
    cce_fwrite_type fw;
    cce_status_type st;
    cce_push_type pu;
    logic [72:0] q[$];
    logic [72:0] exp_obs;
    logic [31:0] seed = 32'h3f1f;
    int n_errors = 0, check_count = 0;
    wire [72:0] obs = {o_pc, fw, o_acc_we, acc, st, pu, o_wc, wcnt, wpre};
    always #4 clk = ~clk;
    cce_exec_unit u_cce_exec_unit (.i_ref_clk(clk), .i_rstn, .i_valid, .i_instr,
        .i_file_rdata(rdata), .i_pc_upper_latch(lat), .o_pc, .o_busy, .o_fwrite(fw),
        .o_acc_we, .o_acc_wdata(acc), .o_status(st), .o_stack_top(pu),
        .o_watchdog_clear(o_wc), .o_watchdog_counter(wcnt), .o_watchdog_prescaler(wpre));
    cce_file_model u_cce_file_model (.i_ref_clk(clk), .i_fwrite(fw), .i_addr(i_instr.faddr),
        .o_rdata(rdata));
    task automatic check(logic [72:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic run(cce_op_type op, logic [6:0] a, logic d, logic [10:0] t, logic [7:0] l);
        logic [12:0] n;
        logic [15:0] f;
        logic [8:0] w;
        logic [3:0] s;
        logic [13:0] p;
        logic [7:0] v;
        @(posedge clk);
        i_valid <= 1;
        i_instr <= '{op, a, d, t};
        lat <= l;
        @(negedge clk);
        {n, f, w, s, p} = {pc + 13'h1, 43'h0};
        v = (op == CCE_OP_COMPLEMENT) ? ~rdata : rdata - 8'h1;
        if (op inside {CCE_OP_COMPLEMENT, CCE_OP_DECREMENT}) begin
            s = {1'b1, v == 8'h0, 2'b0};
            if (d) f = {1'b1, a, v};
            else w = {1'b1, v};
        end
        if (op inside {CCE_OP_CLEAR_FILE, CCE_OP_CLEAR_ACC}) s = 4'hc;
        if (op == CCE_OP_CLEAR_FILE) f = {1'b1, a, 8'h0};
        if (op == CCE_OP_CLEAR_ACC) w = 9'h100;
        if (op == CCE_OP_WATCHDOG_CLEAR) s = 4'h3;
        if (op == CCE_OP_CALL) {n, p} = {l[4:3], t, 1'b1, pc + 13'h1};
        if (op != CCE_OP_NONE) q.push_back({n, f, w, s, p, op == CCE_OP_WATCHDOG_CLEAR, 16'h0});
        pc = n;
        // The instruction after a call must be ignored.
        if (op == CCE_OP_CALL) @(posedge clk) i_instr.op <= CCE_OP_CLEAR_ACC;
    endtask
    always @(negedge clk) if (i_rstn && (fw.we || o_acc_we || st || pu.push || o_wc)) begin
        exp_obs = q.size() ? q.pop_front() : 'x;
        check(obs, exp_obs);
    end
    initial begin
        repeat (5) @(posedge clk);
        i_rstn <= 1;
        pc = 0;
        run(CCE_OP_WATCHDOG_CLEAR, 0, 0, 0, 0);
        run(CCE_OP_CALL, 0, 0, 11'h7ff, 8'h18);
        run(CCE_OP_COMPLEMENT, 0, 0, 0, 0);
        run(CCE_OP_COMPLEMENT, 7'h7f, 1, 0, 0);
        run(CCE_OP_DECREMENT, 2, 0, 0, 0);
        run(CCE_OP_DECREMENT, 1, 1, 0, 0);
        run(CCE_OP_CLEAR_FILE, 5, 0, 0, 0);
        run(CCE_OP_CLEAR_ACC, 0, 0, 0, 0);
        run(CCE_OP_NONE, 0, 0, 0, 0);
        run(CCE_OP_CALL, 0, 0, 0, 8'he7);
        $display("directed ops done");
        repeat (300) begin
            seed = lfsr_next(seed);
            run(cce_op_type'(seed[2:0] % 7), seed[9:3], seed[10], seed[21:11], seed[29:22]);
        end
        @(posedge clk) i_valid <= 0;
        repeat (3) @(posedge clk);
        $display("random ops done");
        if (q.size()) n_errors++;
        stop_test;
    end
    // About 400 cycles are needed; 5000 leaves a wide margin.
    initial begin
        #40000;
        n_errors++;
        stop_test;
    end
endmodule
bind cce_exec_unit cce_exec_chk u_cce_exec_chk (
    .i_ref_clk            (i_ref_clk),
    .i_rstn               (i_rstn),
    .i_valid              (i_valid),
    .i_instr              (i_instr),
    .i_file_rdata         (i_file_rdata),
    .i_pc_upper_latch     (i_pc_upper_latch),
    .o_pc                 (o_pc),
    .o_busy               (o_busy),
    .o_fwrite             (o_fwrite),
    .o_acc_we             (o_acc_we),
    .o_acc_wdata          (o_acc_wdata),
    .o_status             (o_status),
    .o_stack_top          (o_stack_top),
    .o_watchdog_clear     (o_watchdog_clear),
    .o_watchdog_counter   (o_watchdog_counter),
    .o_watchdog_prescaler (o_watchdog_prescaler)
);

// ---- verification/cce_file_model.sv ----
// Purpose: File register model that feeds read data to the unit.
// Assumes: Read is combinational on the presented address.
// Notes:   Location n starts at n-1, so 00h, 01h and ffh exist.
module cce_file_model import cce_pkg::*; (
    input  wire logic           i_ref_clk,
    input  wire cce_fwrite_type i_fwrite,
    input  wire logic [6:0]     i_addr,
    output logic [7:0]          o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem_ff [128];
    initial foreach (mem_ff[n]) mem_ff[n] = 8'(n - 1);
    assign o_rdata = mem_ff[i_addr];
    always @(posedge i_ref_clk) if (i_fwrite.we) mem_ff[i_fwrite.addr] <= i_fwrite.data;
endmodule
